/* sra_pkg.sv */
// sra_pkg: constants, field positions and state types of the row and burst access block
// assumes: one 200 MHz system clock; memory clock, strobe and pins arrive unsynchronised
// Overview of operation
// - calibration registers A/B read back fixed patterns
// - reset register write-only; any write resets
// - activate: chip select low, ca0 low, ca1 high
// - column access: ca0 high, ca1 low; ca2 reads
// - long bursts cut by same kind, even cycles
// - start column from rising ca5-6, falling ca1-2
// - first read datum after read latency clocks
// - strobe preamble low, data on strobe edges
// - seamless reads every half-burst clocks, any bank
// - cut read length twice the command gap
// - write beats captured on strobe edges, whole burst
// - seamless writes every half-burst clocks, any bank
`default_nettype none
package sra_pkg;
	// ==========================================================
	// widths
	localparam int DQ_W = 8;
	localparam int CA_W = 10;
	localparam int MEM_AW = 8;
	localparam int COL_W = 4;
	localparam int INFO_W = 8;
	localparam int PIPE_D = 8;
	localparam int PIPE_IW = 3;
	localparam int LAT_W = 4;
	localparam int BEAT_W = 5;
	// ==========================================================
	// burst length encodings and beat counts
	localparam logic [1:0] BL_ENC_4 = 2'h0;
	localparam logic [1:0] BL_ENC_8 = 2'h1;
	localparam logic [1:0] BL_ENC_16 = 2'h2;
	localparam logic [BEAT_W-1:0] BEATS_4 = 5'h04;
	localparam logic [BEAT_W-1:0] BEATS_8 = 5'h08;
	localparam logic [BEAT_W-1:0] BEATS_16 = 5'h10;
	// ==========================================================
	// mode register addresses and pattern defaults
	localparam logic [7:0] MA_CALIB_A = 8'h20;
	localparam logic [7:0] MA_CALIB_B = 8'h28;
	localparam logic [7:0] MA_SOFT_RESET = 8'h3F;
	localparam logic [7:0] CALIB_A_DEFAULT = 8'hA5;
	localparam logic [7:0] CALIB_B_DEFAULT = 8'h3C;
	// ==========================================================
	// command/address field positions and opcodes
	localparam int BA_LSB = 7;
	localparam int COLR_LSB = 5;
	localparam int COLF_LSB = 1;
	localparam int ROWF_LSB = 0;
	localparam int MAR_LSB = 4;
	localparam int MAF_LSB = 0;
	localparam int AB_BIT = 4;
	localparam int RD_BIT = 2;
	localparam logic [1:0] OP_ACT = 2'h2;
	localparam logic [1:0] OP_COL = 2'h1;
	localparam logic [3:0] OP_MRW = 4'h0;
	localparam logic [3:0] OP_MRR = 4'h8;
	localparam logic [3:0] OP_PRE = 4'hB;
	// info word: [7] mode read, [6] pattern b, [5:4] bank, [3:0] column
	localparam int INF_MRR = 7;
	localparam int INF_PATB = 6;
	localparam int INF_BA = 4;
	// ==========================================================
	// state types
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_ACT = 3'b001,
		CMD_RD = 3'b010,
		CMD_WR = 3'b011,
		CMD_MRW = 3'b100,
		CMD_MRR = 3'b101,
		CMD_PRE = 3'b110
	} sra_cmd_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_PRE = 2'b01,
		RD_BURST = 2'b10
	} sra_rd_t;
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_WAIT = 2'b01,
		WR_BURST = 2'b10
	} sra_wr_t;
endpackage
`default_nettype wire

/* sra_mem.sv */
// sra_mem: small array behind the burst logic, registered read data
// assumes: one clock, write and read never target the same word in one cycle
`timescale 1ns/100ps
`default_nettype none
module sra_mem import sra_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [MEM_AW-1:0] waddr_i,
	input wire logic [DQ_W-1:0] wdata_i,
	input wire logic [MEM_AW-1:0] raddr_i,
	output logic [DQ_W-1:0] rdata_o
);
	logic [DQ_W-1:0] mem_reg [0:(1<<MEM_AW)-1];

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_reg[raddr_i];
	end
endmodule
`default_nettype wire

/* sra_core.sv */
// sra_core: command decode, bank state, read and write burst framing on the memory pins
// assumes: memory clock far slower than clk_sys_i; latency and burst inputs held static
`timescale 1ns/100ps
`default_nettype none
module sra_core import sra_pkg::*; #(
	parameter logic [7:0] CALIB_PATTERN_A = CALIB_A_DEFAULT, // arbitrary value
	parameter logic [7:0] CALIB_PATTERN_B = CALIB_B_DEFAULT  // arbitrary value
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ck_i,
	input wire logic cs_n_i,
	input wire logic [CA_W-1:0] ca_i,
	input wire logic [DQ_W-1:0] dq_i,
	output logic [DQ_W-1:0] dq_o,
	output logic dq_oe_n_o,
	input wire logic dqs_i,
	output logic dqs_o,
	output logic dqs_oe_n_o,
	input wire logic [LAT_W-1:0] read_latency_i,
	input wire logic [LAT_W-1:0] write_latency_i,
	input wire logic [1:0] burst_length_i,
	output logic [3:0] bank_open_o,
	output logic device_reset_o
);
	// ==========================================================
	// pin synchronisers and edge finding
	logic ck_s1_reg, ck_s2_reg, ck_s3_reg, cs_n_s1_reg, cs_n_s2_reg;
	logic dqs_s1_reg, dqs_s2_reg, dqs_s3_reg;
	logic [CA_W-1:0] ca_s1_reg, ca_s2_reg;
	logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
	logic ck_rise, ck_fall, dqs_rise, dqs_fall;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
			cs_n_s1_reg <= 1'b1;
			cs_n_s2_reg <= 1'b1;
			dqs_s1_reg <= 1'b0;
			dqs_s2_reg <= 1'b0;
			dqs_s3_reg <= 1'b0;
			ca_s1_reg <= '0;
			ca_s2_reg <= '0;
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
		end else begin
			ck_s1_reg <= ck_i;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
			cs_n_s1_reg <= cs_n_i;
			cs_n_s2_reg <= cs_n_s1_reg;
			dqs_s1_reg <= dqs_i;
			dqs_s2_reg <= dqs_s1_reg;
			dqs_s3_reg <= dqs_s2_reg;
			ca_s1_reg <= ca_i;
			ca_s2_reg <= ca_s1_reg;
			dq_s1_reg <= dq_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end
	// pins ride the same two stages as the clock, so they stay aligned to its edges
	assign ck_rise = ck_s2_reg & ~ck_s3_reg;
	assign ck_fall = ~ck_s2_reg & ck_s3_reg;
	assign dqs_rise = dqs_s2_reg & ~dqs_s3_reg;
	assign dqs_fall = ~dqs_s2_reg & dqs_s3_reg;

	// ==========================================================
	// command decode and bank state
	sra_cmd_t cmd_reg, cmd_next;
	logic [CA_W-1:0] ca_r_reg, ca_r_next;
	logic [3:0] bank_open_reg, bank_open_next;
	logic [3:0][1:0] row_reg, row_next;
	logic dev_reset_reg, dev_reset_next;
	logic push_rd, push_wr;
	logic [INFO_W-1:0] push_info;
	logic [1:0] cmd_bank;
	logic [COL_W-1:0] col_start;
	logic [7:0] ma_full;
	logic ca_rd_bit;

	assign cmd_bank = ca_r_reg[BA_LSB +: 2];
	// only the low column bits address the small array
	assign col_start = {ca_s2_reg[COLF_LSB +: 2], ca_r_reg[COLR_LSB +: 2]};
	assign ma_full = {ca_s2_reg[MAF_LSB +: 2], ca_r_reg[MAR_LSB +: 6]};
	assign ca_rd_bit = ca_s2_reg[RD_BIT];

	always_comb begin
		cmd_next = cmd_reg;
		ca_r_next = ca_r_reg;
		bank_open_next = bank_open_reg;
		row_next = row_reg;
		dev_reset_next = 1'b0;
		push_rd = 1'b0;
		push_wr = 1'b0;
		push_info = '0;
		if (ck_rise) begin
			ca_r_next = ca_s2_reg;
			cmd_next = CMD_NONE;
			if (!cs_n_s2_reg) begin
				if (ca_s2_reg[1:0] == OP_ACT) begin
					cmd_next = CMD_ACT;
				end else if (ca_s2_reg[1:0] == OP_COL) begin
					cmd_next = ca_rd_bit ? CMD_RD : CMD_WR;
				end else if (ca_s2_reg[3:0] == OP_MRW) begin
					cmd_next = CMD_MRW;
				end else if (ca_s2_reg[3:0] == OP_MRR) begin
					cmd_next = CMD_MRR;
				end else if (ca_s2_reg[3:0] == OP_PRE) begin
					cmd_next = CMD_PRE;
				end
			end
		end else if (ck_fall) begin
			cmd_next = CMD_NONE;
			case (cmd_reg)
				CMD_ACT: begin
					bank_open_next[cmd_bank] = 1'b1;
					row_next[cmd_bank] = ca_s2_reg[ROWF_LSB +: 2];
				end
				CMD_PRE: begin
					if (ca_r_reg[AB_BIT]) begin
						bank_open_next = 4'h0;
					end else begin
						bank_open_next[cmd_bank] = 1'b0;
					end
				end
				CMD_RD: begin
					push_rd = 1'b1;
					push_info = {2'b00, cmd_bank, col_start};
				end
				CMD_WR: begin
					push_wr = 1'b1;
					push_info = {2'b00, cmd_bank, col_start};
				end
				CMD_MRR: begin
					// reset register is write-only: a read of it returns nothing
					if (ma_full == MA_CALIB_A || ma_full == MA_CALIB_B) begin
						push_rd = 1'b1;
						push_info = {1'b1, ma_full == MA_CALIB_B, 6'h00};
					end
				end
				CMD_MRW: begin
					dev_reset_next = (ma_full == MA_SOFT_RESET);
				end
				default: begin
				end
			endcase
		end
		if (dev_reset_reg) begin
			cmd_next = CMD_NONE;
			bank_open_next = 4'h0;
			push_rd = 1'b0;
			push_wr = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_reg <= CMD_NONE;
			ca_r_reg <= '0;
			bank_open_reg <= 4'h0;
			row_reg <= '0;
			dev_reset_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			ca_r_reg <= ca_r_next;
			bank_open_reg <= bank_open_next;
			row_reg <= row_next;
			dev_reset_reg <= dev_reset_next;
		end
	end

	// ==========================================================
	// latency delay lines, one slot per memory clock rise
	logic [PIPE_D-1:0] rp_valid_reg, rp_valid_next, wp_valid_reg, wp_valid_next;
	logic [PIPE_D-1:0][INFO_W-1:0] rp_info_reg, rp_info_next, wp_info_reg, wp_info_next;
	logic [LAT_W-1:0] rl_idx, pre_idx, wl_idx;
	logic rd_start, rd_pre, wr_arm;
	logic [INFO_W-1:0] start_info;
	logic [BEAT_W-1:0] bl_beats;

	// latency must lie in 2..8 for reads and 1..8 for writes
	assign rl_idx = read_latency_i - 4'h1;
	assign pre_idx = read_latency_i - 4'h2;
	assign wl_idx = write_latency_i - 4'h1;
	assign rd_start = rp_valid_reg[rl_idx[PIPE_IW-1:0]];
	assign rd_pre = rp_valid_reg[pre_idx[PIPE_IW-1:0]];
	assign start_info = rp_info_reg[rl_idx[PIPE_IW-1:0]];
	assign wr_arm = wp_valid_reg[wl_idx[PIPE_IW-1:0]];

	always_comb begin
		case (burst_length_i)
			BL_ENC_8: bl_beats = BEATS_8;
			BL_ENC_16: bl_beats = BEATS_16;
			default: bl_beats = BEATS_4;
		endcase
	end

	always_comb begin
		rp_valid_next = rp_valid_reg;
		rp_info_next = rp_info_reg;
		wp_valid_next = wp_valid_reg;
		wp_info_next = wp_info_reg;
		if (ck_rise) begin
			rp_valid_next = {rp_valid_reg[PIPE_D-2:0], 1'b0};
			rp_info_next = {rp_info_reg[PIPE_D-2:0], 8'h00};
			wp_valid_next = {wp_valid_reg[PIPE_D-2:0], 1'b0};
			wp_info_next = {wp_info_reg[PIPE_D-2:0], 8'h00};
		end
		if (push_rd) begin
			rp_valid_next[0] = 1'b1;
			rp_info_next[0] = push_info;
		end
		if (push_wr) begin
			wp_valid_next[0] = 1'b1;
			wp_info_next[0] = push_info;
		end
		if (dev_reset_reg) begin
			rp_valid_next = '0;
			wp_valid_next = '0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rp_valid_reg <= '0;
			rp_info_reg <= '0;
			wp_valid_reg <= '0;
			wp_info_reg <= '0;
		end else begin
			rp_valid_reg <= rp_valid_next;
			rp_info_reg <= rp_info_next;
			wp_valid_reg <= wp_valid_next;
			wp_info_reg <= wp_info_next;
		end
	end

	// ==========================================================
	// read burst and strobe framing
	sra_rd_t rd_state_reg, rd_state_next;
	logic [BEAT_W-1:0] rd_left_reg, rd_left_next;
	logic [INFO_W-1:0] rd_info_reg, rd_info_next, beat_info;
	logic fire_reg, fire_next, phase_reg, phase_next;
	logic [MEM_AW-1:0] rd_addr_reg, rd_addr_next;
	logic [DQ_W-1:0] dq_reg, dq_next, mem_rdata;
	logic dqs_reg, dqs_next, dq_oe_n_reg, dq_oe_n_next, dqs_oe_n_reg, dqs_oe_n_next;

	always_comb begin
		rd_state_next = rd_state_reg;
		rd_left_next = rd_left_reg;
		rd_info_next = rd_info_reg;
		beat_info = rd_info_reg;
		fire_next = 1'b0;
		phase_next = phase_reg;
		rd_addr_next = rd_addr_reg;
		if (ck_rise && rd_start) begin
			// a new start reloads the count, so a cut burst keeps only the beats already sent
			rd_state_next = RD_BURST;
			rd_left_next = (start_info[INF_MRR] ? BEATS_4 : bl_beats) - 5'h01;
			beat_info = start_info;
			fire_next = 1'b1;
			phase_next = 1'b1;
		end else if ((ck_rise || ck_fall) && rd_state_reg == RD_BURST && rd_left_reg != 5'h00) begin
			rd_left_next = rd_left_reg - 5'h01;
			beat_info[COL_W-1:0] = rd_info_reg[COL_W-1:0] + 4'h1;
			fire_next = 1'b1;
			phase_next = ck_rise;
		end else if (ck_rise && rd_pre) begin
			rd_state_next = RD_PRE;
		end else if (ck_rise && rd_state_reg == RD_BURST) begin
			rd_state_next = RD_IDLE;
		end
		if (fire_next) begin
			rd_info_next = beat_info;
			rd_addr_next = {beat_info[INF_BA +: 2], row_reg[beat_info[INF_BA +: 2]], beat_info[COL_W-1:0]};
		end
		if (dev_reset_reg) begin
			rd_state_next = RD_IDLE;
			fire_next = 1'b0;
		end
	end

	// pin stage lags the beat by one cycle while the array read completes
	always_comb begin
		dq_next = dq_reg;
		dqs_next = dqs_reg;
		dqs_oe_n_next = (rd_state_reg == RD_IDLE);
		dq_oe_n_next = (rd_state_reg != RD_BURST);
		if (rd_state_reg == RD_PRE) begin
			dqs_next = 1'b0;
		end
		if (fire_reg) begin
			dqs_next = phase_reg;
			if (rd_info_reg[INF_MRR]) begin
				dq_next = rd_info_reg[INF_PATB] ? CALIB_PATTERN_B : CALIB_PATTERN_A;
			end else begin
				dq_next = mem_rdata;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_state_reg <= RD_IDLE;
			rd_left_reg <= '0;
			rd_info_reg <= '0;
			fire_reg <= 1'b0;
			phase_reg <= 1'b0;
			rd_addr_reg <= '0;
			dq_reg <= '0;
			dqs_reg <= 1'b0;
			dq_oe_n_reg <= 1'b1;
			dqs_oe_n_reg <= 1'b1;
		end else begin
			rd_state_reg <= rd_state_next;
			rd_left_reg <= rd_left_next;
			rd_info_reg <= rd_info_next;
			fire_reg <= fire_next;
			phase_reg <= phase_next;
			rd_addr_reg <= rd_addr_next;
			dq_reg <= dq_next;
			dqs_reg <= dqs_next;
			dq_oe_n_reg <= dq_oe_n_next;
			dqs_oe_n_reg <= dqs_oe_n_next;
		end
	end

	// ==========================================================
	// write capture on strobe edges
	sra_wr_t wr_state_reg, wr_state_next;
	logic [BEAT_W-1:0] wr_left_reg, wr_left_next;
	logic [INFO_W-1:0] wr_info_reg, wr_info_next;
	logic wr_we;
	logic [MEM_AW-1:0] wr_addr;

	assign wr_addr = {wr_info_reg[INF_BA +: 2], row_reg[wr_info_reg[INF_BA +: 2]], wr_info_reg[COL_W-1:0]};

	always_comb begin
		wr_state_next = wr_state_reg;
		wr_left_next = wr_left_reg;
		wr_info_next = wr_info_reg;
		// preamble is low, so the first beat waits for a rising strobe
		wr_we = (wr_state_reg == WR_WAIT && dqs_rise) || (wr_state_reg == WR_BURST && (dqs_rise || dqs_fall));
		if (wr_we) begin
			wr_left_next = wr_left_reg - 5'h01;
			wr_info_next[COL_W-1:0] = wr_info_reg[COL_W-1:0] + 4'h1;
			wr_state_next = (wr_left_reg == 5'h01) ? WR_IDLE : WR_BURST;
		end
		if (ck_rise && wr_arm) begin
			wr_state_next = WR_WAIT;
			wr_left_next = bl_beats;
			wr_info_next = wp_info_reg[wl_idx[PIPE_IW-1:0]];
		end
		if (dev_reset_reg) begin
			wr_state_next = WR_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_state_reg <= WR_IDLE;
			wr_left_reg <= '0;
			wr_info_reg <= '0;
		end else begin
			wr_state_reg <= wr_state_next;
			wr_left_reg <= wr_left_next;
			wr_info_reg <= wr_info_next;
		end
	end

	sra_mem u_mem (
		.clk_sys_i(clk_sys_i),
		.we_i(wr_we),
		.waddr_i(wr_addr),
		.wdata_i(dq_s2_reg),
		.raddr_i(rd_addr_next),
		.rdata_o(mem_rdata)
	);

	assign dq_o = dq_reg;
	assign dqs_o = dqs_reg;
	assign dq_oe_n_o = dq_oe_n_reg;
	assign dqs_oe_n_o = dqs_oe_n_reg;
	assign bank_open_o = bank_open_reg;
	assign device_reset_o = dev_reset_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	act_bank_open_a: assert property ((ck_fall && cmd_reg == CMD_ACT && !dev_reset_reg) |=> bank_open_reg[$past(cmd_bank)]) else $error("activate did not open bank");
	col_decode_a: assert property ((ck_rise && !cs_n_s2_reg && ca_s2_reg[1:0] == OP_COL && !dev_reset_reg) |=> (cmd_reg == ($past(ca_rd_bit) ? CMD_RD : CMD_WR))) else $error("column access misdecoded");
	col_form_a: assert property ((ck_fall && cmd_reg == CMD_RD && !dev_reset_reg) |=> (rp_valid_reg[0] && rp_info_reg[0][COL_W-1:0] == $past(col_start))) else $error("start column wrong");
	read_start_a: assert property ((ck_rise && rd_start && !dev_reset_reg) |-> ##2 (!dq_oe_n_o && dqs_o)) else $error("read data not driven at latency");
	preamble_low_a: assert property ($fell(dqs_oe_n_o) |-> !dqs_o) else $error("strobe not low at preamble");
	release_a: assert property ((ck_rise && !rd_start && !rd_pre && rd_state_reg == RD_BURST && rd_left_reg == 5'h00) |-> ##2 (dq_oe_n_o && dqs_oe_n_o)) else $error("pins not released after burst");
	mrr_pattern_a: assert property ((fire_reg && rd_info_reg[INF_MRR] && !rd_info_reg[INF_PATB]) |=> (dq_o == CALIB_PATTERN_A)) else $error("pattern A not returned");
	soft_reset_a: assert property ((ck_fall && cmd_reg == CMD_MRW && ma_full == MA_SOFT_RESET && !dev_reset_reg) |=> device_reset_o ##1 (bank_open_o == 4'h0 && rd_state_reg == RD_IDLE)) else $error("reset write ignored");
	rd_interrupt_a: assert property ((ck_rise && rd_start && rd_state_reg == RD_BURST && !start_info[INF_MRR] && !dev_reset_reg) |=> (rd_left_reg == $past(bl_beats) - 5'h01)) else $error("interrupting read not reloaded");
	wr_arm_a: assert property ((ck_rise && wr_arm && !dev_reset_reg) |=> (wr_state_reg == WR_WAIT && wr_left_reg == $past(bl_beats))) else $error("write not armed at latency");
	wr_done_a: assert property ((wr_we && wr_left_reg == 5'h01 && !(ck_rise && wr_arm) && !dev_reset_reg) |=> (wr_state_reg == WR_IDLE)) else $error("write burst overran");

	seamless_read_c: cover property (ck_rise && rd_start && rd_state_reg == RD_BURST && rd_left_reg == 5'h00);
	cut_read_c: cover property (ck_rise && rd_start && rd_state_reg == RD_BURST && rd_left_reg != 5'h00);
	mrr_read_c: cover property (fire_reg && rd_info_reg[INF_MRR]);
	write_done_c: cover property (wr_we && wr_left_reg == 5'h01);
	soft_reset_c: cover property (device_reset_o);
endmodule
`default_nettype wire

/* sra_host.sv */
// sra_host: behavioural memory controller driving ck, commands and write data
// assumes: caller spaces commands legally; ck runs only while cyc is busy
`timescale 1ns/100ps
`default_nettype none
module sra_host import sra_pkg::*; (
	input wire logic clk_sys_i,
	output logic ck_o,
	output logic cs_n_o,
	output logic [CA_W-1:0] ca_o,
	output logic [DQ_W-1:0] dq_o,
	output logic dqs_o
);
	initial begin
		ck_o = 1'b0;
		cs_n_o = 1'b1;
		ca_o = 10'h000;
		dq_o = 8'h00;
		dqs_o = 1'b0;
	end
	// ==========================================================
	// one ck period of 13 + 12 clk_sys cycles; wb sends two write beats
	task automatic cyc(input logic cs_n, input logic [CA_W-1:0] cr, input logic [CA_W-1:0] cf,
		input logic wb, input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1);
		for (int i = 0; i < 25; i++) begin
			@(negedge clk_sys_i);
			if (i == 0) begin
				ck_o = 1'b1;
				cs_n_o = cs_n;
				ca_o = cs_n ? ~ca_o : cr;
				// released dq keeps changing so stale data cannot match
				if (!wb) dq_o = ~dq_o;
			end
			if (i == 13) begin
				ck_o = 1'b0;
				if (!cs_n) ca_o = cf;
			end
			// data set up 5 cycles before each strobe edge, strobe low as preamble
			if (wb && i == 3) dq_o = d0;
			if (wb && i == 8) dqs_o = 1'b1;
			if (wb && i == 16) dq_o = d1;
			if (wb && i == 21) dqs_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* testbench.sv */
// testbench: row table of write/read-back cases, then mode, seamless and cut bursts
// assumes: read latency 3, write latency 1, host model on the memory pins
`timescale 1ns/100ps
`default_nettype none
module testbench import sra_pkg::*;;
	logic clk_sys_i, rst_i, ck, cs_n, dqs_h, dq_oe_n_o, dqs_o, dqs_oe_n_o, device_reset_o, dqs_q;
	logic [CA_W-1:0] ca;
	logic [DQ_W-1:0] dq_h, dq_o;
	logic [3:0] read_latency_i, write_latency_i, bank_open_o;
	logic [1:0] burst_length_i, bl, b;
	logic [3:0] col;
	logic [7:0] base;
	logic [7:0] beat_q[$], exp_q[$];
	int failures, compares, t, t_cmd, lat, pre_n, rst_cnt;
	// rows: {burst code, bank, start column, first data byte}
	localparam logic [15:0] ROWS [4] = '{16'h0010, 16'h1D20, 16'h6430, 16'hB040};
	sra_core dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ck_i(ck), .cs_n_i(cs_n), .ca_i(ca),
		.dq_i(dq_h), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dqs_i(dqs_h), .dqs_o(dqs_o),
		.dqs_oe_n_o(dqs_oe_n_o), .read_latency_i(read_latency_i), .write_latency_i(write_latency_i),
		.burst_length_i(burst_length_i), .bank_open_o(bank_open_o), .device_reset_o(device_reset_o));
	sra_host host_u (.clk_sys_i(clk_sys_i), .ck_o(ck), .cs_n_o(cs_n), .ca_o(ca), .dq_o(dq_h), .dqs_o(dqs_h));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// ==========================================================
	// beat monitor: a beat is every strobe change while data is driven
	always @(posedge clk_sys_i) begin
		t = t + 1;
		if (dq_oe_n_o === 1'b0 && dqs_o !== dqs_q) begin
			if (beat_q.size() == 0) lat = t - t_cmd;
			beat_q.push_back(dq_o);
		end
		if (dqs_oe_n_o === 1'b0 && dq_oe_n_o === 1'b1) pre_n = pre_n + 1;
		if (device_reset_o === 1'b1) rst_cnt = rst_cnt + 1;
		dqs_q = dqs_o;
	end
	// ==========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) host_u.cyc(1'b1, 10'h000, 10'h000, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic cmd(input logic [CA_W-1:0] cr, input logic [CA_W-1:0] cf);
		host_u.cyc(1'b0, cr, cf, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic act(input logic [1:0] bk);
		cmd({1'b0, bk, 5'h00, 2'b10}, 10'h000);
		idle(2);
	endtask
	task automatic rd(input logic [1:0] bk, input logic [3:0] c);
		t_cmd = t;
		pre_n = 0;
		cmd({1'b0, bk, c[1:0], 5'h05}, {7'h00, c[3:2], 1'b0});
	endtask
	task automatic expect_beats(input string nm);
		chk(nm, 16'(exp_q.size()), 16'(beat_q.size()));
		for (int k = 0; k < exp_q.size() && k < beat_q.size(); k++) chk(nm, 16'(exp_q[k]), 16'(beat_q[k]));
		beat_q.delete();
		exp_q.delete();
	endtask
	task automatic fill(input logic [7:0] v, input int n);
		for (int k = 0; k < n; k++) exp_q.push_back(v + 8'(k));
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	// ==========================================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		read_latency_i = 4'h3;
		write_latency_i = 4'h1;
		burst_length_i = BL_ENC_4;
		t = 0;
		dqs_q = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		chk("reset outputs", 16'h00C0, {dq_o, dq_oe_n_o, dqs_oe_n_o, dqs_o, bank_open_o, device_reset_o});
		repeat (4) @(negedge clk_sys_i);
		for (int r = 0; r < 4; r++) begin
			{bl, b, col, base} = ROWS[r];
			burst_length_i = bl;
			act(b);
			chk("bank open", 16'(4'h1 << b), 16'(bank_open_o));
			cmd({1'b0, b, col[1:0], 5'h01}, {7'h00, col[3:2], 1'b0});
			for (int k = 0; k < (2 << bl); k++) host_u.cyc(1'b1, 10'h000, 10'h000, 1'b1, base + 8'(2 * k),
				base + 8'(2 * k + 1));
			idle(4);
			beat_q.delete();
			fill(base, 4 << bl);
			rd(b, col);
			idle(6 + (2 << bl));
			expect_beats("read beats");
			chk("preamble", 16'h0001, 16'(pre_n >= 24 && pre_n <= 26));
			chk("read latency", 16'h0001, 16'(lat >= 76 && lat <= 86));
			cmd(10'h01B, 10'h000);
			idle(2);
			chk("bank closed", 16'h0000, 16'(bank_open_o));
		end
		burst_length_i = BL_ENC_4;
		repeat (4) exp_q.push_back(CALIB_A_DEFAULT);
		cmd(10'h208, 10'h000);
		idle(7);
		expect_beats("pattern a");
		repeat (4) exp_q.push_back(CALIB_B_DEFAULT);
		cmd(10'h288, 10'h000);
		idle(7);
		expect_beats("pattern b");
		cmd(10'h3F8, 10'h000);
		idle(7);
		expect_beats("reset reg read");
		act(2'h0);
		rst_cnt = 0;
		cmd(10'h3F0, 10'h000);
		idle(2);
		chk("reset pulse", 16'h0001, 16'(rst_cnt));
		chk("banks after reset", 16'h0000, 16'(bank_open_o));
		act(2'h0);
		act(2'h1);
		fill(8'h10, 4);
		fill(8'h20, 4);
		rd(2'h0, 4'h0);
		idle(1);
		rd(2'h1, 4'hD);
		idle(8);
		expect_beats("seamless reads");
		burst_length_i = BL_ENC_8;
		act(2'h2);
		act(2'h3);
		fill(8'h30, 4);
		fill(8'h40, 8);
		rd(2'h2, 4'h4);
		idle(1);
		rd(2'h3, 4'h0);
		idle(10);
		expect_beats("cut read");
		cmd(10'h10B, 10'h000);
		idle(2);
		chk("single bank closed", 16'h000B, 16'(bank_open_o));
		wrap_up();
	end
endmodule
`default_nettype wire
